// [rtl/ccrb_core_config.sv]
// Functional notes
// - Device-control moves privileged; numbers reserved
// - Primary bit 1 selects full parity recovery
// - Primary bit 4 enables parity readback
// - Primary bit 10 disables store gathering
// - Primary bit 11 stops auxiliary broadcast
// - Primary bit 16 stops trace broadcast
// - Primary bit 17 guarantees icache touch fill
// - Primary bit 18 guarantees dcache touch fill
// - Primary bit 23 forces alignment exceptions
// - Primary 28:29 speculative extra line count
// - Primary 30:31 speculative fill doubleword threshold
// - Secondary 0:7 inverts icache word parity
// - Secondary 8:11 invert icache, dcache tag parity
// - Secondary 12:14 invert dcache data, U, dirty
// - Secondary bit 15 forces cache ops miss
// - Secondary 16:19 inverts MMU tag parity
// - Secondary bit 20 forces full-line flush
// - Secondary bit 24 selects timer clock source
// - Critical interrupt saves return address, state
// - Condition flags are eight 4-bit fields
`timescale 1ns/1ps
`include "ccrb_defines.svh"

module ccrb_core_config
    import ccrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register moves from the pipeline
    input wire ccrb_req_t req,
    // Configuration fields to the pipeline, caches, MMU and timer
    output ccrb_cfg0_t cfg0,
    output ccrb_cfg1_t cfg1,
    // Move response
    output logic [31:0] rdata,
    output logic ack,
    output logic priv_fault,
    output logic dcr_unmapped,
    // Critical interrupt capture
    input wire ccrb_crit_t crit,
    // Condition flags update from execution
    input wire logic [7:0] cf_field_we,
    input wire logic [31:0] cf_field_wdata,
    output logic [31:0] condition_flags,
    // Loop count, critical save and compare registers
    output logic [31:0] loop_count,
    output logic [31:0] critical_return_address,
    output logic [31:0] critical_saved_state,
    output logic [31:0] data_address_compare_1,
    output logic [31:0] data_address_compare_2,
    // Timer clock selection
    input wire logic timer_clock_in,
    output logic timer_tick
);

    // Stored configuration words, reserved positions always zero
    logic [31:0] cfg0_q;
    logic [31:0] cfg1_q;
    logic [31:0] next_cfg0;
    logic [31:0] next_cfg1;
    // Software-visible data registers
    logic [31:0] next_loop;
    logic [31:0] next_data_address_compare_1;
    logic [31:0] next_data_address_compare_2;
    logic [31:0] next_cra;
    logic [31:0] next_css;
    logic [31:0] next_cf;
    // Move response
    logic [31:0] next_rdata;
    logic next_ack;
    logic next_priv_fault;
    logic next_dcr_unmapped;
    // Timer source sampling
    logic tclk_q;
    logic next_tclk;
    logic tclk_rise;
    logic next_tick;
    // Access decode
    logic access_ok;
    logic do_write;
    logic do_read;
    logic user_fault;
    logic dcr_move;

    // Supervisor-only numbers; the loop count is user accessible
    function automatic logic is_supervisor_spr(input logic [9:0] n);
        return n != `CCRB_SPR_LOOP_COUNT;
    endfunction

    function automatic logic is_mapped(input logic [9:0] n);
        unique case (n)
            `CCRB_SPR_LOOP_COUNT, `CCRB_SPR_CRIT_RET_ADDR,
            `CCRB_SPR_CRIT_STATE, `CCRB_SPR_DAC_1, `CCRB_SPR_DAC_2,
            `CCRB_SPR_CFG_SECONDARY, `CCRB_SPR_CFG_PRIMARY:
                return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Only documented fields are copied; reserved positions stay zero,
    // so a careless write cannot enable undefined behaviour
    function automatic ccrb_cfg0_t pack_cfg0(input logic [31:0] w);
        ccrb_cfg0_t src;
        ccrb_cfg0_t c;
        src = ccrb_cfg0_t'(w);
        c = ccrb_cfg0_t'(32'h00000000);
        c.parity_recovery_full = src.parity_recovery_full;
        c.cache_read_parity_enable =
            src.cache_read_parity_enable;
        c.store_gather_disable = src.store_gather_disable;
        c.aux_unit_broadcast_disable =
            src.aux_unit_broadcast_disable;
        c.trace_broadcast_disable = src.trace_broadcast_disable;
        c.guaranteed_icache_touch = src.guaranteed_icache_touch;
        c.guaranteed_dcache_touch = src.guaranteed_dcache_touch;
        c.force_access_alignment = src.force_access_alignment;
        c.spec_line_count = src.spec_line_count;
        c.spec_line_threshold = src.spec_line_threshold;
        return c;
    endfunction

    function automatic ccrb_cfg1_t pack_cfg1(input logic [31:0] w);
        ccrb_cfg1_t src;
        ccrb_cfg1_t c;
        src = ccrb_cfg1_t'(w);
        c = ccrb_cfg1_t'(32'h00000000);
        c.icache_word_parity_invert =
            src.icache_word_parity_invert;
        c.icache_tag_parity_invert =
            src.icache_tag_parity_invert;
        c.dcache_tag_parity_invert =
            src.dcache_tag_parity_invert;
        c.dcache_data_parity_invert =
            src.dcache_data_parity_invert;
        c.dcache_ubit_parity_invert =
            src.dcache_ubit_parity_invert;
        c.dcache_dirty_parity_invert =
            src.dcache_dirty_parity_invert;
        c.force_cache_op_miss = src.force_cache_op_miss;
        c.mmu_tag_parity_invert = src.mmu_tag_parity_invert;
        c.full_line_flush = src.full_line_flush;
        c.timer_source_select = src.timer_source_select;
        return c;
    endfunction

    // Low two bits of the return address are reserved
    function automatic logic [31:0] pack_ret_addr(input logic [31:0] w);
        return w & `CCRB_CRA_WMASK;
    endfunction

    // Access decode
    assign dcr_move = req.valid && req.device_control_reg;
    assign user_fault = req.valid && !req.supervisor
        && (req.device_control_reg || is_supervisor_spr(req.num));
    assign access_ok = req.valid && !req.device_control_reg && is_mapped(req.num)
        && !user_fault;
    assign do_write = access_ok && req.write;
    assign do_read = access_ok && !req.write;

    // Configuration registers; a write shows at the next edge
    always_comb begin
        next_cfg0 = cfg0_q;
        next_cfg1 = cfg1_q;
        if (do_write && req.num == `CCRB_SPR_CFG_PRIMARY) begin
            next_cfg0 = pack_cfg0(req.wdata);
        end
        if (do_write && req.num == `CCRB_SPR_CFG_SECONDARY) begin
            next_cfg1 = pack_cfg1(req.wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg0_q <= `CCRB_CFG0_RESET;
            cfg1_q <= `CCRB_CFG1_RESET;
        end else begin
            cfg0_q <= next_cfg0;
            cfg1_q <= next_cfg1;
        end
    end

    // Loop count and data address compare registers
    always_comb begin
        next_loop = loop_count;
        next_data_address_compare_1 = data_address_compare_1;
        next_data_address_compare_2 = data_address_compare_2;
        if (do_write) begin
            unique case (req.num)
                `CCRB_SPR_LOOP_COUNT: next_loop = req.wdata;
                `CCRB_SPR_DAC_1: next_data_address_compare_1 = req.wdata;
                `CCRB_SPR_DAC_2: next_data_address_compare_2 = req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            loop_count <= 32'h00000000;
            data_address_compare_1 <= 32'h00000000;
            data_address_compare_2 <= 32'h00000000;
        end else begin
            loop_count <= next_loop;
            data_address_compare_1 <= next_data_address_compare_1;
            data_address_compare_2 <= next_data_address_compare_2;
        end
    end

    // Critical save registers; a software move in the same cycle wins,
    // being the later and deliberate update of the same register
    always_comb begin
        next_cra = critical_return_address;
        next_css = critical_saved_state;
        if (crit.valid) begin
            next_cra = pack_ret_addr(crit.ret_addr);
            next_css = crit.state;
        end
        if (do_write && req.num == `CCRB_SPR_CRIT_RET_ADDR) begin
            next_cra = pack_ret_addr(req.wdata);
        end
        if (do_write && req.num == `CCRB_SPR_CRIT_STATE) begin
            next_css = req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            critical_return_address <= 32'h00000000;
            critical_saved_state <= 32'h00000000;
        end else begin
            critical_return_address <= next_cra;
            critical_saved_state <= next_css;
        end
    end

    // Read data; reserved bits read as zero since they are never stored
    always_comb begin
        next_rdata = rdata;
        if (do_read) begin
            unique case (req.num)
                `CCRB_SPR_CFG_PRIMARY: next_rdata = cfg0_q;
                `CCRB_SPR_CFG_SECONDARY: next_rdata = cfg1_q;
                `CCRB_SPR_LOOP_COUNT: next_rdata = loop_count;
                `CCRB_SPR_CRIT_RET_ADDR: next_rdata = critical_return_address;
                `CCRB_SPR_CRIT_STATE: next_rdata = critical_saved_state;
                `CCRB_SPR_DAC_1: next_rdata = data_address_compare_1;
                `CCRB_SPR_DAC_2: next_rdata = data_address_compare_2;
                default: next_rdata = 32'h00000000;
            endcase
        end else if (req.valid) begin
            // Refused moves and writes return no data
            next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Every move is answered one cycle later, refused ones included
    always_comb begin
        next_ack = req.valid;
        next_priv_fault = user_fault;
        // No device-control register exists behind this core
        next_dcr_unmapped = dcr_move && req.supervisor;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack <= 1'b0;
            priv_fault <= 1'b0;
            dcr_unmapped <= 1'b0;
        end else begin
            ack <= next_ack;
            priv_fault <= next_priv_fault;
            dcr_unmapped <= next_dcr_unmapped;
        end
    end

    // Condition flags: field k occupies bits 4k..4k+3 from the MSB
    always_comb begin
        next_cf = condition_flags;
        for (int k = 0; k < 8; k++) begin
            if (cf_field_we[7 - k]) begin
                next_cf[31 - 4 * k -: 4] =
                    cf_field_wdata[31 - 4 * k -: 4];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            condition_flags <= 32'h00000000;
        end else begin
            condition_flags <= next_cf;
        end
    end

    // One sample per core edge catches every rising edge, because the
    // timer input toggles at no more than half the core rate
    always_comb begin
        next_tclk = timer_clock_in;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tclk_q <= 1'b0;
        end else begin
            tclk_q <= next_tclk;
        end
    end

    assign tclk_rise = timer_clock_in && !tclk_q;

    // Tick source select
    always_comb begin
        if (cfg1_q[7]) begin
            next_tick = tclk_rise;
        end else begin
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= next_tick;
        end
    end

    // Configuration fields go straight to the pipeline, caches and MMU
    assign cfg0 = ccrb_cfg0_t'(cfg0_q);
    // Gathering, broadcast, touch and alignment controls
    assign cfg1 = ccrb_cfg1_t'(cfg1_q);
    // Parity insert, forced miss and full-line flush controls

endmodule

// [rtl/ccrb_defines.svh]
`ifndef CCRB_DEFINES_SVH
`define CCRB_DEFINES_SVH

// Special-purpose register numbers
`define CCRB_SPR_LOOP_COUNT      10'h009
`define CCRB_SPR_CRIT_RET_ADDR   10'h03A
`define CCRB_SPR_CRIT_STATE      10'h03B
`define CCRB_SPR_DAC_1           10'h13C
`define CCRB_SPR_DAC_2           10'h13D
`define CCRB_SPR_CFG_SECONDARY   10'h378
`define CCRB_SPR_CFG_PRIMARY     10'h3B3

// Writable bits; reserved positions are held at zero (LSB-0 numbering)
`define CCRB_CFG0_WMASK          32'h4830E10F
`define CCRB_CFG1_WMASK          32'hFFFFF880
`define CCRB_CRA_WMASK           32'hFFFFFFFC

// Configuration reset values
`define CCRB_CFG0_RESET          32'h00000000
`define CCRB_CFG1_RESET          32'h00000000

`endif

// [rtl/ccrb_pkg.sv]
package ccrb_pkg;

    // Primary configuration, MSB-first field order (bit 0 is [31])
    typedef struct packed {
        logic       rsvd0;
        logic       parity_recovery_full;
        logic [1:0] rsvd2;
        logic       cache_read_parity_enable;
        logic [4:0] rsvd5;
        logic       store_gather_disable;
        logic       aux_unit_broadcast_disable;
        logic [3:0] rsvd12;
        logic       trace_broadcast_disable;
        logic       guaranteed_icache_touch;
        logic       guaranteed_dcache_touch;
        logic [3:0] rsvd19;
        logic       force_access_alignment;
        logic [3:0] rsvd24;
        logic [1:0] spec_line_count;
        logic [1:0] spec_line_threshold;
    } ccrb_cfg0_t;

    typedef struct packed {
        logic [7:0] icache_word_parity_invert;
        logic [1:0] icache_tag_parity_invert;
        logic [1:0] dcache_tag_parity_invert;
        logic       dcache_data_parity_invert;
        logic       dcache_ubit_parity_invert;
        logic       dcache_dirty_parity_invert;
        logic       force_cache_op_miss;
        logic [3:0] mmu_tag_parity_invert;
        logic       full_line_flush;
        logic [2:0] rsvd21;
        logic       timer_source_select;
        logic [6:0] rsvd25;
    } ccrb_cfg1_t;

    // Register move request from the pipeline
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       device_control_reg;
        logic       supervisor;
        logic [9:0] num;
        logic [31:0] wdata;
    } ccrb_req_t;

    // Critical interrupt capture
    typedef struct packed {
        logic        valid;
        logic [31:0] ret_addr;
        logic [31:0] state;
    } ccrb_crit_t;

endpackage

// [verif/ccrb_core_config_sva.sv]
`timescale 1ns/1ps
`include "ccrb_defines.svh"
module ccrb_core_config_sva
    import ccrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Requests and events
    input wire ccrb_req_t req,
    input wire ccrb_crit_t crit,
    input wire logic [7:0] cf_field_we,
    input wire logic [31:0] cf_field_wdata,
    input wire logic timer_clock_in,
    // Results
    input wire ccrb_cfg0_t cfg0,
    input wire ccrb_cfg1_t cfg1,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic priv_fault,
    input wire logic dcr_unmapped,
    input wire logic [31:0] condition_flags,
    input wire logic [31:0] critical_return_address,
    input wire logic [31:0] critical_saved_state,
    input wire logic timer_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire sw = req.valid && req.write && req.supervisor && !req.device_control_reg;
    sequence s_dcr; req.valid && req.device_control_reg; endsequence
    sequence s_core_src; !cfg1.timer_source_select [*2]; endsequence
    property p_ack; req.valid |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_dsup; s_dcr ##0 req.supervisor |=>
        dcr_unmapped && !priv_fault && rdata == 32'h0; endproperty
    a_dsup: assert property (p_dsup) else $error("dcr move");
    property p_dusr; s_dcr ##0 !req.supervisor |=>
        priv_fault && rdata == 32'h0; endproperty
    a_dusr: assert property (p_dusr) else $error("dcr user");
    property p_cfg0; sw && req.num == 10'h3B3 |=>
        cfg0 == ($past(req.wdata) & `CCRB_CFG0_WMASK); endproperty
    a_cfg0: assert property (p_cfg0) else $error("cfg0");
    property p_cfg1; sw && req.num == 10'h378 |=>
        cfg1 == ($past(req.wdata) & `CCRB_CFG1_WMASK); endproperty
    a_cfg1: assert property (p_cfg1) else $error("cfg1");
    property p_crit; crit.valid && !req.valid |=> critical_saved_state ==
        $past(crit.state) && critical_return_address ==
        ($past(crit.ret_addr) & 32'hFFFFFFFC); endproperty
    a_crit: assert property (p_crit) else $error("crit");
    property p_cf; cf_field_we == 8'h80 |=> condition_flags == {$past(
        cf_field_wdata[31:28]), $past(condition_flags[27:0])}; endproperty
    a_cf: assert property (p_cf) else $error("flags");
    property p_tick; s_core_src |-> timer_tick; endproperty
    a_tick: assert property (p_tick) else $error("core tick");
    property p_ext; cfg1.timer_source_select && $rose(timer_clock_in) |->
        ##[1:3] timer_tick; endproperty
    a_ext: assert property (p_ext) else $error("timer tick");
endmodule

// [verif/ccrb_pipe_model.sv]
`timescale 1ns/1ps
module ccrb_pipe_model (
    // Core clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Timer clock at a quarter of the core rate, under the half-rate limit
    output logic timer_clock_in
);
    logic [1:0] div;
    always_ff @(posedge clk) begin
        div <= rstn ? div + 2'h1 : 2'h0;
    end
    assign timer_clock_in = div[1];
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "ccrb_defines.svh"
module testbench
    import ccrb_pkg::*;
;
    logic clk, rstn, ack, pf, du, tci, tick;
    ccrb_req_t req;
    ccrb_crit_t crit;
    ccrb_cfg0_t cfg0;
    ccrb_cfg1_t cfg1;
    logic [7:0] we;
    logic [31:0] wd, rdata, cf, lc, cra, css, d1, d2, v, exp, m;
    logic [9:0] n;
    logic [9:0] nums [7] = '{10'h009, 10'h03A, 10'h03B, 10'h13C, 10'h13D,
        10'h378, 10'h3B3};
    int mismatches, cmp_count, ticks;
    ccrb_core_config u_ccrb_core_config (.clk(clk), .rstn(rstn), .req(req),
        .cfg0(cfg0), .cfg1(cfg1), .rdata(rdata), .ack(ack), .priv_fault(pf),
        .dcr_unmapped(du), .crit(crit), .cf_field_we(we),
        .cf_field_wdata(wd), .condition_flags(cf), .loop_count(lc),
        .critical_return_address(cra), .critical_saved_state(css),
        .data_address_compare_1(d1), .data_address_compare_2(d2),
        .timer_clock_in(tci), .timer_tick(tick));
    ccrb_pipe_model u_ccrb_pipe_model (.clk(clk), .rstn(rstn),
        .timer_clock_in(tci));
    function automatic logic [31:0] wmask(logic [9:0] k);
        case (k)
            10'h3B3: return `CCRB_CFG0_WMASK;
            10'h378: return `CCRB_CFG1_WMASK;
            10'h03A: return `CCRB_CRA_WMASK;
            default: return 32'hFFFFFFFF;
        endcase
    endfunction
    function automatic logic [31:0] merge(logic [31:0] o, logic [7:0] e,
            logic [31:0] d);
        for (int f = 0; f < 8; f++)
            if (e[f]) o[f*4 +: 4] = d[f*4 +: 4];
        return o;
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    // One idle cycle follows each move so valid never toggles twice
    task automatic move(logic w, logic s, logic d, logic [9:0] k,
            logic [31:0] x, logic [31:0] rd, logic [2:0] fl);
        req = '{1'b1, w, d, s, k, x};
        @(posedge clk) #1;
        chk(rdata, rd);
        chk({29'h0, ack, pf, du}, {29'h0, fl});
        req.valid = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 3000);
        mismatches++;
        wrap_up();
    end
    initial begin
        v = $urandom(32'hD1666700);
        rstn = 1'b0;
        req = '0;
        crit = '0;
        we = 8'h00;
        wd = 32'h0;
        m = 32'h0;
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        chk(cfg0, 32'h0);
        chk(cfg1, 32'h0);
        for (int i = 0; i < 21; i++) begin
            n = nums[i % 7];
            v = (i < 7) ? 32'hFFFFFFFF : $urandom & wmask(n);
            exp = v & wmask(n);
            move(1, 1, 0, n, v, 32'h0, 3'b100);
            move(0, 1, 0, n, 32'h0, exp, 3'b100);
        end
        move(1, 0, 0, 10'h3B3, ~exp, 32'h0, 3'b110);
        move(1, 1, 1, 10'h3B3, ~exp, 32'h0, 3'b101);
        move(0, 0, 1, 10'h010, 32'h0, 32'h0, 3'b110);
        chk(cfg0, exp);
        move(1, 0, 0, 10'h009, v, 32'h0, 3'b100);
        chk(lc, v);
        for (int i = 0; i < 8; i++) begin
            crit = '{1'b1, $urandom, $urandom};
            we = (i == 0) ? 8'h80 : 8'($urandom);
            wd = $urandom;
            m = merge(m, we, wd);
            @(posedge clk) #1;
            chk(cra, crit.ret_addr & 32'hFFFFFFFC);
            chk(css, crit.state);
            chk(cf, m);
        end
        crit.valid = 1'b0;
        we = 8'h00;
        move(1, 1, 0, 10'h378, 32'h80, 32'h0, 3'b100);
        repeat (4) @(posedge clk);
        ticks = 0;
        repeat (40) begin
            @(posedge clk) #1;
            ticks += tick;
        end
        chk(ticks, 10);
        wrap_up();
    end
endmodule
bind ccrb_core_config ccrb_core_config_sva u_ccrb_core_config_sva (
    .clk(clk), .rstn(rstn), .req(req), .crit(crit), .cfg0(cfg0),
    .cf_field_we(cf_field_we), .cf_field_wdata(cf_field_wdata),
    .timer_clock_in(timer_clock_in), .cfg1(cfg1), .rdata(rdata), .ack(ack),
    .priv_fault(priv_fault), .dcr_unmapped(dcr_unmapped),
    .condition_flags(condition_flags), .timer_tick(timer_tick),
    .critical_return_address(critical_return_address),
    .critical_saved_state(critical_saved_state));
